// [dacr_pkg.sv]
// Constants shared by the readback and status logic of the quad converter.
// Assumes a 24-bit serial frame, MSB first, framed by an active-low select.
package dacr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Frame layout
   localparam int unsigned FRAME_BITS  = 24;
   localparam int unsigned DATA_BITS   = 16;
   localparam int unsigned CH_NUM      = 4;
   localparam int unsigned RW_BIT      = 23;
   localparam int unsigned ADDR_HI_BIT = 22;
   localparam int unsigned ADDR_LO_BIT = 21;
   localparam int unsigned SEL_MSB     = 20;
   localparam int unsigned SEL_LSB     = 16;
   localparam logic [4:0]  FRAME_CNT   = 5'h18;
   localparam logic [7:0]  PAD_BITS    = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Register selector: group in bits 4..2, channel in bits 1..0
   localparam logic [2:0] SELG_DATA   = 3'h0;
   localparam logic [2:0] SELG_CTRL   = 3'h1;
   localparam logic [2:0] SELG_GAIN   = 3'h2;
   localparam logic [2:0] SELG_OFFSET = 3'h3;
   localparam logic [2:0] SELG_CLEAR  = 3'h4;
   localparam logic [2:0] SELG_SLEW   = 3'h5;
   localparam logic [2:0] SELG_MISC   = 3'h6;
   localparam logic [1:0] MISC_STATUS = 2'h0;
   localparam logic [1:0] MISC_MAIN   = 2'h1;
   localparam logic [1:0] MISC_SUPPLY = 2'h2;
   localparam logic [4:0] SEL_STATUS  = 5'h18;

   ////////////////////////////////////////////////////////////////////////
   // Status word bit positions
   localparam int unsigned ST_SUPPLY_LSB = 12;
   localparam int unsigned ST_TOGGLE     = 11;
   localparam int unsigned ST_PEC        = 10;
   localparam int unsigned ST_RAMP       = 9;
   localparam int unsigned ST_OVERTEMP   = 8;
   localparam int unsigned ST_VOUT_LSB   = 4;
   localparam int unsigned ST_IOUT_LSB   = 0;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Control fields read from other registers
   localparam int unsigned MAIN_STAT_EVERY_BIT = 11;
   localparam int unsigned SLEW_ENABLE_BIT     = 12;

   typedef enum logic [1:0] {
      DACR_IDLE  = 2'b01,
      DACR_FRAME = 2'b10
   } dacr_state_e;

endpackage

// [dacr_sync3.sv]
// Three-stage synchroniser with an agreement filter, one lane per bit.
// Assumes inputs are asynchronous to sys_clk; output follows once the
// second and third stages agree.
`timescale 1ns/1ns
module dacr_sync3 #(
   parameter int unsigned      WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] stable_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } dacr_sync_s;

   dacr_sync_s sync_ff;
   dacr_sync_s nxt_sync;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_sync    = sync_ff;
      nxt_sync.s1 = async_in;
      nxt_sync.s2 = sync_ff.s1;
      nxt_sync.s3 = sync_ff.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // Stage one feeds stage two only, to keep metastability contained
         if (sync_ff.s2[i] == sync_ff.s3[i]) begin
            nxt_sync.q[i] = sync_ff.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_ff <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign stable_out = sync_ff.q;

endmodule // dacr_sync3

// [dacr_readback.sv]
// Serial readback path and status word of the quad output converter.
// Assumes the register contents, fault sources and slew progress come
// from logic on sys_clk; the serial pins and address straps are async.
//
// How it works
// - Frame with bit 23 set is a read request, not a write.
// - Address straps and selector bits 20..16 choose the register read.
// - Low sixteen bits of a read request are ignored.
// - Selected register shifts out during the next frame the host sends.
// - Selectors 0..3 return channel A..D data registers.
// - Selectors 4..7 return channel A..D control registers.
// - Selectors 8..11 give gain, 12..15 give offset, A..D.
// - Selectors 16..19 return channel A..D clear-code registers.
// - Selectors 20..23 return channel A..D slew control registers.
// - Selector 24 status, 25 main control, 26 supply control.
// - Status word is read-only, built internally, never written.
// - Status-every-write bit set: status shifts out in every frame without a pending read.
// - Bits 15..12 supply D..A, 11 toggle, 10 packet error, 9 ramp, 8 hot.
// - Bits 7..4 voltage faults D..A, bits 3..0 current faults D..A.
// - Current mode: lost compliance sets supply flag and current fault.
// - Voltage mode: supply flag set when regulation to 15 V fails.
// - Supply flags never drive the shared fault output.
// - User toggle bit follows the software register bit.
// - Ramp bit high while any slew-enabled channel is still stepping.
// - Packet error bit set on a failed packet check.
`timescale 1ns/1ns
module dacr_readback
   import dacr_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic                 spi_sclk,
   input  wire logic                 spi_sync_n,
   input  wire logic                 spi_sdin,
   output      logic                 spi_sdo,
   input  wire logic                 device_addr_hi,
   input  wire logic                 device_addr_lo,
   input  wire logic [DATA_BITS-1:0] dac_data    [CH_NUM],
   input  wire logic [DATA_BITS-1:0] dac_ctrl    [CH_NUM],
   input  wire logic [DATA_BITS-1:0] dac_gain    [CH_NUM],
   input  wire logic [DATA_BITS-1:0] dac_offset  [CH_NUM],
   input  wire logic [DATA_BITS-1:0] dac_clear   [CH_NUM],
   input  wire logic [DATA_BITS-1:0] dac_slew    [CH_NUM],
   input  wire logic [DATA_BITS-1:0] main_ctrl,
   input  wire logic [DATA_BITS-1:0] supply_ctrl,
   input  wire logic                 user_toggle_bit,
   input  wire logic [CH_NUM-1:0]    chan_current_mode,
   input  wire logic [CH_NUM-1:0]    compliance_lost,
   input  wire logic [CH_NUM-1:0]    regulation_lost,
   input  wire logic [CH_NUM-1:0]    vout_fault_in,
   input  wire logic [CH_NUM-1:0]    iout_fault_in,
   input  wire logic                 over_temp_in,
   input  wire logic [CH_NUM-1:0]    chan_stepping,
   input  wire logic                 pec_fail_pulse,
   output      logic [DATA_BITS-1:0] status_word,
   output      logic                 fault_out,
   output      logic                 fault_oe
);

   typedef struct packed {
      dacr_state_e          state;
      logic                 sclk_q;
      logic                 sync_q;
      logic [4:0]           bit_cnt;
      logic [FRAME_BITS-1:0] rx_sr;
      logic [FRAME_BITS-1:0] tx_sr;
      logic                 pend_valid;
      logic [4:0]           pend_sel;
      logic [DATA_BITS-1:0] status;
      logic                 pec_err;
      logic                 sdo;
      logic                 fault_out;
      logic                 fault_oe;
   } dacr_state_s;

   localparam dacr_state_s STATE_RESET = '{
      state:      DACR_IDLE,
      sclk_q:     1'b0,
      sync_q:     1'b1,
      bit_cnt:    5'h00,
      rx_sr:      24'h000000,
      tx_sr:      24'h000000,
      pend_valid: 1'b0,
      pend_sel:   5'h00,
      status:     STATUS_RESET,
      pec_err:    1'b0,
      sdo:        1'b0,
      fault_out:  1'b0,
      fault_oe:   1'b0
   };

   dacr_state_s rb_ff;
   dacr_state_s nxt_rb;

   logic [4:0]        pins_s;
   logic              sclk_s;
   logic              sync_s;
   logic              sdin_s;
   logic              addr_hi_s;
   logic              addr_lo_s;
   logic [CH_NUM-1:0] supply_flag;
   logic [CH_NUM-1:0] iout_flag;
   logic [CH_NUM-1:0] ramp_chan;
   logic [DATA_BITS-1:0] status_live;
   logic              fault_src;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; select idles high so it resets high, else the
   // first cycle after reset would look like a frame start. The serial
   // clock needs no care: a rising edge on it is never acted upon.
   dacr_sync3 #(
      .WIDTH     (5),
      .RESET_VAL (5'h02)
   ) u_pin_sync (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .async_in   ({device_addr_lo, device_addr_hi, spi_sdin,
                    spi_sync_n, spi_sclk}),
      .stable_out (pins_s)
   );

   assign sclk_s    = pins_s[0];
   assign sync_s    = pins_s[1];
   assign sdin_s    = pins_s[2];
   assign addr_hi_s = pins_s[3];
   assign addr_lo_s = pins_s[4];

   ////////////////////////////////////////////////////////////////////////
   // Per-channel status sources
   // A channel reports supply trouble one way only, picked by its
   // output mode; in current mode, compliance loss also counts as a current fault.
   generate
      for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_chan
         assign supply_flag[ch] = chan_current_mode[ch] ?
                                  compliance_lost[ch] : regulation_lost[ch];
         assign iout_flag[ch]   = iout_fault_in[ch] |
                                  (chan_current_mode[ch] & compliance_lost[ch]);
         // Slewing without slew control enabled is not a ramp
         assign ramp_chan[ch]   = dac_slew[ch][SLEW_ENABLE_BIT] &
                                  chan_stepping[ch];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic                  sclk_fall;
      logic                  sync_fall;
      logic                  sync_rise;
      logic                  addr_match;
      logic                  pec_clr;
      logic [DATA_BITS-1:0]  read_word;
      logic [FRAME_BITS-1:0] tx_load;
      sclk_fall  = 1'b0;
      sync_fall  = 1'b0;
      sync_rise  = 1'b0;
      addr_match = 1'b0;
      pec_clr    = 1'b0;
      read_word  = 16'h0000;
      tx_load    = 24'h000000;
      nxt_rb     = rb_ff;

      sclk_fall  = rb_ff.sclk_q & ~sclk_s;
      sync_fall  = rb_ff.sync_q & ~sync_s;
      sync_rise  = ~rb_ff.sync_q & sync_s;
      nxt_rb.sclk_q = sclk_s;
      nxt_rb.sync_q = sync_s;

      // Straps are sampled live; changing them mid-frame only affects
      // the frame whose end sees the new value.
      addr_match = (rb_ff.rx_sr[ADDR_HI_BIT] == addr_hi_s) &&
                   (rb_ff.rx_sr[ADDR_LO_BIT] == addr_lo_s);

      // Register selection for a pending read
      case (rb_ff.pend_sel[4:2])
         SELG_DATA:   read_word = dac_data[rb_ff.pend_sel[1:0]];
         SELG_CTRL:   read_word = dac_ctrl[rb_ff.pend_sel[1:0]];
         SELG_GAIN:   read_word = dac_gain[rb_ff.pend_sel[1:0]];
         SELG_OFFSET: read_word = dac_offset[rb_ff.pend_sel[1:0]];
         SELG_CLEAR:  read_word = dac_clear[rb_ff.pend_sel[1:0]];
         SELG_SLEW:   read_word = dac_slew[rb_ff.pend_sel[1:0]];
         SELG_MISC: begin
            case (rb_ff.pend_sel[1:0])
               MISC_STATUS: read_word = rb_ff.status;
               MISC_MAIN:   read_word = main_ctrl;
               MISC_SUPPLY: read_word = supply_ctrl;
               default:     read_word = 16'h0000;
            endcase
         end
         default: read_word = 16'h0000;
      endcase

      case (rb_ff.state)
         DACR_IDLE: begin
            if (sync_fall) begin
               nxt_rb.state   = DACR_FRAME;
               nxt_rb.bit_cnt = 5'h00;
               // A pending readback outranks the every-write status so
               // the host never loses the answer it asked for.
               if (rb_ff.pend_valid) begin
                  tx_load = {PAD_BITS, read_word};
                  pec_clr = (rb_ff.pend_sel == SEL_STATUS);
               end else if (main_ctrl[MAIN_STAT_EVERY_BIT]) begin
                  tx_load = {PAD_BITS, rb_ff.status};
                  pec_clr = 1'b1;
               end
               // The answer is consumed by this frame whatever kind it is
               nxt_rb.pend_valid = 1'b0;
               nxt_rb.tx_sr      = tx_load;
               nxt_rb.sdo        = tx_load[FRAME_BITS-1];
            end
         end
         DACR_FRAME: begin
            if (sync_rise) begin
               nxt_rb.state = DACR_IDLE;
               nxt_rb.sdo   = 1'b0;
               // Short or long frames are dropped whole
               // Requests for another device on the shared select too
               if ((rb_ff.bit_cnt == FRAME_CNT) &&
                   rb_ff.rx_sr[RW_BIT] && addr_match) begin
                  nxt_rb.pend_valid = 1'b1;
                  // Only the selector is kept; bits 15..0 go nowhere
                  nxt_rb.pend_sel = rb_ff.rx_sr[SEL_MSB:SEL_LSB];
               end
            end else if (sclk_fall) begin
               if (rb_ff.bit_cnt < FRAME_CNT) begin
                  nxt_rb.rx_sr = {rb_ff.rx_sr[FRAME_BITS-2:0], sdin_s};
                  nxt_rb.tx_sr = {rb_ff.tx_sr[FRAME_BITS-2:0], 1'b0};
                  nxt_rb.sdo   = rb_ff.tx_sr[FRAME_BITS-2];
                  nxt_rb.bit_cnt = rb_ff.bit_cnt + 5'h01;
               end else begin
                  // Overlong frame: mark it so the end check fails
                  // and park the count so more edges cannot wrap it
                  nxt_rb.bit_cnt = 5'h1F;
               end
            end
         end
         default: begin
            nxt_rb = STATE_RESET;
         end
      endcase

      // A failure arriving as the flag is shifted out wins over the clear
      // The flag is sticky, yet a failure in the cycle before a status load is cleared unreported
      if (pec_fail_pulse) begin
         nxt_rb.pec_err = 1'b1;
      end else if (pec_clr) begin
         nxt_rb.pec_err = 1'b0;
      end

      // Status is rebuilt from live sources every cycle; no write path
      nxt_rb.status = status_live;

      // Supply-derived flags are left out of the shared fault line
      nxt_rb.fault_out = 1'b0;
      nxt_rb.fault_oe  = fault_src;
   end

   ////////////////////////////////////////////////////////////////////////
   // Live status word, one cycle ahead of the register that holds it.
   // The packet error bit comes from the sticky flag, so it lags its
   // failure pulse by two cycles in total.
   always_comb begin
      status_live = STATUS_RESET;
      status_live[ST_SUPPLY_LSB +: CH_NUM] = supply_flag;
      status_live[ST_TOGGLE]   = user_toggle_bit;
      status_live[ST_PEC]      = rb_ff.pec_err;
      status_live[ST_RAMP]     = |ramp_chan;
      status_live[ST_OVERTEMP] = over_temp_in;
      status_live[ST_VOUT_LSB +: CH_NUM] = vout_fault_in;
      status_live[ST_IOUT_LSB +: CH_NUM] = iout_flag;
   end

   // Only pin-level faults pull the shared line; a user who wants the
   // supply flags must poll the status word for them.
   assign fault_src = over_temp_in | (|vout_fault_in) | (|iout_fault_in);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rb_ff <= STATE_RESET;
      end else begin
         rb_ff <= nxt_rb;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Every output is a flip-flop of the state struct
   assign spi_sdo     = rb_ff.sdo;
   assign status_word = rb_ff.status;
   assign fault_out   = rb_ff.fault_out;
   assign fault_oe    = rb_ff.fault_oe;

endmodule // dacr_readback

// [dacr_chk.sv]
// Checker for the readback block: status timing and fault output relations.
// Assumes status_word lags its sources by one sys_clk cycle.
`timescale 1ns/1ns
module dacr_chk
   import dacr_pkg::*;
(
   input wire logic                 sys_clk,
   input wire logic                 reset_n,
   input wire logic                 spi_sync_n,
   input wire logic                 spi_sdo,
   input wire logic [DATA_BITS-1:0] dac_slew [CH_NUM],
   input wire logic                 user_toggle_bit,
   input wire logic [CH_NUM-1:0]    chan_current_mode,
   input wire logic [CH_NUM-1:0]    compliance_lost,
   input wire logic [CH_NUM-1:0]    regulation_lost,
   input wire logic [CH_NUM-1:0]    vout_fault_in,
   input wire logic [CH_NUM-1:0]    iout_fault_in,
   input wire logic                 over_temp_in,
   input wire logic [CH_NUM-1:0]    chan_stepping,
   input wire logic                 pec_fail_pulse,
   input wire logic [DATA_BITS-1:0] status_word,
   input wire logic                 fault_out,
   input wire logic                 fault_oe
);
   default clocking @(posedge sys_clk); endclocking
   // The first edge after reset compares reset contents against live
   // sources, so every check waits one cycle past the release
   logic chk_armed;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         chk_armed <= 1'b0;
      end else begin
         chk_armed <= 1'b1;
      end
   end
   default disable iff (!reset_n || !chk_armed);
   logic [CH_NUM-1:0] slew_en;
   logic [CH_NUM-1:0] cur_lost;
   always_comb begin
      for (int i = 0; i < CH_NUM; i++) slew_en[i] = dac_slew[i][SLEW_ENABLE_BIT];
      cur_lost = chan_current_mode & compliance_lost;
   end
   ////////////////////////////////////////////////////////////////////////
   toggle_follow_a: assert property (status_word[ST_TOGGLE] == $past(user_toggle_bit))
      else $error("user toggle flag wrong");
   supply_flag_a: assert property (status_word[15:12] ==
      $past(cur_lost | (~chan_current_mode & regulation_lost)))
      else $error("supply flags wrong");
   iout_fault_a: assert property (status_word[3:0] ==
      $past(iout_fault_in | cur_lost)) else $error("current faults wrong");
   vout_fault_a: assert property (status_word[7:4] == $past(vout_fault_in))
      else $error("voltage faults wrong");
   hot_flag_a: assert property (status_word[ST_OVERTEMP] == $past(over_temp_in))
      else $error("over temperature flag wrong");
   ramp_flag_a: assert property (status_word[ST_RAMP] ==
      $past(|(chan_stepping & slew_en))) else $error("ramp flag wrong");
   pec_set_a: assert property (pec_fail_pulse |-> ##2 status_word[ST_PEC])
      else $error("packet error flag not set");
   pec_cause_a: assert property ($rose(status_word[ST_PEC]) |->
      $past(pec_fail_pulse, 2)) else $error("packet error flag set alone");
   fault_pin_a: assert property (!fault_out)
      else $error("fault pin value not low");
   supply_quiet_a: assert property ((!over_temp_in && vout_fault_in == 4'h0 &&
      iout_fault_in == 4'h0) [*3] |=> !fault_oe) else $error("fault pin from supply");
   sdo_idle_a: assert property (spi_sync_n [*8] |-> !spi_sdo)
      else $error("data out busy between frames");
   cover property (pec_fail_pulse);
   cover property (status_word[ST_RAMP]);
   cover property ($fell(spi_sync_n));
endmodule // dacr_chk

bind dacr_readback dacr_chk u_chk (.sys_clk, .reset_n, .spi_sync_n, .spi_sdo,
   .dac_slew, .user_toggle_bit, .chan_current_mode, .compliance_lost,
   .regulation_lost, .vout_fault_in, .iout_fault_in, .over_temp_in,
   .chan_stepping, .pec_fail_pulse, .status_word, .fault_out, .fault_oe);

// [dacr_host.sv]
// Host model: drives 24-bit frames MSB first, samples data out per bit.
// Assumes sys_clk at 10 ns; serial clock idles high and stops between frames.
`timescale 1ns/1ns
module dacr_host (
   input  wire logic sys_clk,
   output      logic spi_sclk,
   output      logic spi_sync_n,
   output      logic spi_sdin,
   input  wire logic spi_sdo
);
   initial begin
      spi_sclk = 1'b1;
      spi_sync_n = 1'b1;
      spi_sdin = 1'b0;
   end
   // Bit 23 marks a read; the caller issues the collecting frame next
   task automatic xfer(input logic [23:0] din, output logic [23:0] dout);
      @(posedge sys_clk);
      #1 spi_sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdin = din[i];
         #80 dout[i] = spi_sdo;
         spi_sclk = 1'b0;
         #80 spi_sclk = 1'b1;
      end
      #40 spi_sync_n = 1'b1;
      // Released line shows the inverse so a stale bit is never mistaken
      spi_sdin = ~din[0];
      #100;
   endtask
endmodule // dacr_host

// [test_dacr_readback.sv]
// Testbench: chained readback of all selectors, status modes, fault output.
// Assumes dacr_host and the bound checker; 100 MHz clock, 160 ns link clock.
`timescale 1ns/1ns
module test_dacr_readback
   import dacr_pkg::*;
   ;
   logic        sys_clk = 1'b0, reset_n = 1'b0;
   logic        spi_sclk, spi_sync_n, spi_sdin, spi_sdo;
   logic        device_addr_hi, device_addr_lo, user_toggle_bit;
   logic        over_temp_in, pec_fail_pulse, fault_out, fault_oe;
   logic [15:0] dac_data [4], dac_ctrl [4], dac_gain [4];
   logic [15:0] dac_offset [4], dac_clear [4], dac_slew [4];
   logic [15:0] main_ctrl, supply_ctrl, status_word;
   logic [3:0]  chan_current_mode, compliance_lost, regulation_lost;
   logic [3:0]  vout_fault_in, iout_fault_in, chan_stepping;
   logic [15:0] lfsr = 16'h6FE6;
   logic [23:0] rx;
   int          n_mismatch = 0, check_count = 0;
   always #5 sys_clk = ~sys_clk;
   dacr_readback dut (.sys_clk, .reset_n, .spi_sclk, .spi_sync_n, .spi_sdin,
      .spi_sdo, .device_addr_hi, .device_addr_lo, .dac_data, .dac_ctrl,
      .dac_gain, .dac_offset, .dac_clear, .dac_slew, .main_ctrl,
      .supply_ctrl, .user_toggle_bit, .chan_current_mode, .compliance_lost,
      .regulation_lost, .vout_fault_in, .iout_fault_in, .over_temp_in,
      .chan_stepping, .pec_fail_pulse, .status_word, .fault_out, .fault_oe);
   dacr_host u_host (.sys_clk, .spi_sclk, .spi_sync_n, .spi_sdin, .spi_sdo);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function automatic logic [15:0] exp_status(input logic pec);
      logic [3:0] en, cl;
      for (int i = 0; i < 4; i++) en[i] = dac_slew[i][SLEW_ENABLE_BIT];
      cl = chan_current_mode & compliance_lost;
      return {cl | (~chan_current_mode & regulation_lost), user_toggle_bit,
         pec, |(chan_stepping & en), over_temp_in, vout_fault_in,
         iout_fault_in | cl};
   endfunction
   function automatic logic [15:0] exp_reg(input logic [4:0] s);
      case (s[4:2])
         3'h0: return dac_data[s[1:0]];
         3'h1: return dac_ctrl[s[1:0]];
         3'h2: return dac_gain[s[1:0]];
         3'h3: return dac_offset[s[1:0]];
         3'h4: return dac_clear[s[1:0]];
         3'h5: return dac_slew[s[1:0]];
         3'h6: return s[1:0] == 2'h0 ? exp_status(1'b0) :
            s[1:0] == 2'h1 ? main_ctrl : s[1:0] == 2'h2 ? supply_ctrl : 16'h0000;
         default: return 16'h0000;
      endcase
   endfunction
   function automatic logic [23:0] rd_frame(input logic [4:0] s);
      return {1'b1, device_addr_hi, device_addr_lo, s, rnd()};
   endfunction
   task automatic check(input string what, input logic [23:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 4; i++) begin
         {dac_data[i], dac_ctrl[i], dac_gain[i]} = {rnd(), rnd(), rnd()};
         {dac_offset[i], dac_clear[i], dac_slew[i]} = {rnd(), rnd(), rnd()};
      end
      {main_ctrl, supply_ctrl, device_addr_hi, device_addr_lo} = {16'h0000, rnd(), 2'h2};
      {chan_current_mode, compliance_lost, regulation_lost, vout_fault_in} = rnd();
      {iout_fault_in, chan_stepping, user_toggle_bit, over_temp_in} = 10'(rnd());
      pec_fail_pulse = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      repeat (8) @(posedge sys_clk);
      u_host.xfer(rd_frame(5'h00), rx);
      for (int s = 1; s <= 32; s++) begin
         u_host.xfer(rd_frame(5'(s)), rx);
         check("readback", rx, {8'h00, exp_reg(5'(s - 1))});
      end
      $display("test chained readback done");
      main_ctrl[MAIN_STAT_EVERY_BIT] = 1'b1;
      u_host.xfer({1'b1, ~device_addr_hi, device_addr_lo, 21'h000000}, rx);
      check("pending first", rx, {8'h00, exp_reg(5'h00)});
      u_host.xfer({1'b0, 23'(rnd())}, rx);
      check("every write", rx, {8'h00, exp_status(1'b0)});
      @(posedge sys_clk) #1 pec_fail_pulse = 1'b1;
      @(posedge sys_clk) #1 pec_fail_pulse = 1'b0;
      u_host.xfer({1'b0, 23'(rnd())}, rx);
      check("pec set", rx, {8'h00, exp_status(1'b1)});
      u_host.xfer({1'b0, 23'(rnd())}, rx);
      check("pec clear", rx, {8'h00, exp_status(1'b0)});
      $display("test status every write done");
      main_ctrl[MAIN_STAT_EVERY_BIT] = 1'b0;
      for (int k = 0; k < 8; k++) begin
         {chan_current_mode, compliance_lost, regulation_lost, vout_fault_in} = rnd();
         {iout_fault_in, chan_stepping, user_toggle_bit, over_temp_in} = 10'(rnd());
         if (k % 2 == 0) {vout_fault_in, iout_fault_in, over_temp_in} = 9'h000;
         dac_slew[k % 4] = rnd();
         u_host.xfer(rd_frame(SEL_STATUS), rx);
         u_host.xfer(rd_frame(SEL_STATUS), rx);
         check("status", rx, {8'h00, exp_status(1'b0)});
         check("fault oe", {23'h0, fault_oe},
            {23'h0, over_temp_in | (|vout_fault_in) | (|iout_fault_in)});
      end
      $display("test random status done");
      stop_test();
   end
   initial begin
      #400_000;
      n_mismatch++;
      stop_test();
   end
endmodule // test_dacr_readback
